// ===== logic/bst_pkg.sv
// Contract
// - the block offers a four-signal test port: test clock, test data in, test data out and mode select.
// - the controller is a sixteen-state machine held in a four-bit state register.
// - every controller step uses the mode select level taken at a rising test clock edge, set up by the tester beforehand.
// - after power-up reset the controller sits in test-logic-reset with no test clock activity needed.
// - five test clock cycles with mode select high bring the controller to test-logic-reset from any state.
// - the extest, sample/preload and bypass instructions are decoded, plus optional idcode.
// - instruction-path states work on the instruction register, data-path states on the selected data register.
// - three data registers exist, bypass, identification and boundary scan, each placed between data in and out.
// - any instruction that selects no other register selects bypass.
// - a 32-bit identification register with low byte, id number, part number and version fields shifts out serially.
// - every pin has a boundary cell that captures the pin and, under extest, drives it.
// - the controller makes the capture, shift and update strobes for all registers from mode select and test clock.
package bst_pkg;
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PAUSE_DR, BST_EX2_DR,
    BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR, BST_PAUSE_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_t;
  localparam int BST_IR_W = 4;
  localparam logic [3:0] BST_OP_EXTEST = 4'h0;
  localparam logic [3:0] BST_OP_SAMPLE = 4'h1;
  localparam logic [3:0] BST_OP_IDCODE = 4'h2;
  localparam logic [3:0] BST_OP_BYPASS = 4'hf;
  localparam logic [3:0] BST_IR_RESET = BST_OP_IDCODE;
  localparam logic [3:0] BST_IR_CAPTURE = 4'h1;
  localparam int BST_SYNC_STAGES = 2;
  localparam int BST_ID_LSB_POS = 0;
  localparam int BST_ID_NUM_POS = 8;
  localparam int BST_ID_PART_POS = 12;
  localparam int BST_ID_VER_POS = 28;
endpackage

// ===== logic/bst_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
// strobes from the controller to the register logic, one system clock wide
interface bst_ctrl_if;
  logic rise;
  logic fall;
  bst_pkg::bst_state_t state;
  modport ctrl (output rise, output fall, output state);
  modport regs (input rise, input fall, input state);
endinterface
`default_nettype wire

// ===== logic/bst_tap_fsm.sv
`timescale 1ns/1ps
`default_nettype none
// synchronises tck/tms, finds tck edges and steps the controller
module bst_tap_fsm (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic tck_pin,
  input wire logic tms_pin,
  bst_ctrl_if.ctrl cif
);
  import bst_pkg::*;
  logic [BST_SYNC_STAGES-1:0] tck_s_r, tms_s_r;
  logic tck_d_r, tck_d_nxt;
  bst_state_t st_r, st_nxt;
  logic rise_c;

  // two-flop synchronisers; only the last stage is read
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tck_s_r <= '0;
      tms_s_r <= '1;
    end else begin
      tck_s_r <= {tck_s_r[BST_SYNC_STAGES-2:0], tck_pin};
      tms_s_r <= {tms_s_r[BST_SYNC_STAGES-2:0], tms_pin};
    end
  end

  assign rise_c = tck_s_r[BST_SYNC_STAGES-1] & ~tck_d_r;

  // next state per tms at the rising tck edge
  always_comb begin
    tck_d_nxt = tck_s_r[BST_SYNC_STAGES-1];
    st_nxt = st_r;
    if (rise_c) begin
      case (st_r)
        BST_TLR: st_nxt = tms_s_r[1] ? BST_TLR : BST_RTI;
        BST_RTI: st_nxt = tms_s_r[1] ? BST_SEL_DR : BST_RTI;
        BST_SEL_DR: st_nxt = tms_s_r[1] ? BST_SEL_IR : BST_CAP_DR;
        BST_CAP_DR: st_nxt = tms_s_r[1] ? BST_EX1_DR : BST_SH_DR;
        BST_SH_DR: st_nxt = tms_s_r[1] ? BST_EX1_DR : BST_SH_DR;
        BST_EX1_DR: st_nxt = tms_s_r[1] ? BST_UPD_DR : BST_PAUSE_DR;
        BST_PAUSE_DR: st_nxt = tms_s_r[1] ? BST_EX2_DR : BST_PAUSE_DR;
        BST_EX2_DR: st_nxt = tms_s_r[1] ? BST_UPD_DR : BST_SH_DR;
        BST_UPD_DR: st_nxt = tms_s_r[1] ? BST_SEL_DR : BST_RTI;
        BST_SEL_IR: st_nxt = tms_s_r[1] ? BST_TLR : BST_CAP_IR;
        BST_CAP_IR: st_nxt = tms_s_r[1] ? BST_EX1_IR : BST_SH_IR;
        BST_SH_IR: st_nxt = tms_s_r[1] ? BST_EX1_IR : BST_SH_IR;
        BST_EX1_IR: st_nxt = tms_s_r[1] ? BST_UPD_IR : BST_PAUSE_IR;
        BST_PAUSE_IR: st_nxt = tms_s_r[1] ? BST_EX2_IR : BST_PAUSE_IR;
        BST_EX2_IR: st_nxt = tms_s_r[1] ? BST_UPD_IR : BST_SH_IR;
        default: st_nxt = tms_s_r[1] ? BST_SEL_DR : BST_RTI;
      endcase
    end
  end

  // state register, test-logic-reset on power-up
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= BST_TLR;
      tck_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tck_d_r <= tck_d_nxt;
    end
  end

  assign cif.rise = rise_c;
  assign cif.fall = ~tck_s_r[BST_SYNC_STAGES-1] & tck_d_r;
  assign cif.state = st_r;
endmodule
`default_nettype wire

// ===== logic/bst_tap_top.sv
`timescale 1ns/1ps
`default_nettype none
// boundary-scan test port: instruction register, bypass, id and boundary cells
module bst_tap_top #(
  parameter int NPINS = 8,
  parameter logic [7:0] ID_LSB = 8'h01, // arbitrary value
  parameter logic [3:0] ID_NUM = 4'h1, // arbitrary value
  parameter logic [15:0] ID_PART = 16'h0001, // arbitrary value
  parameter logic [3:0] ID_VER = 4'h0 // arbitrary value
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [NPINS-1:0] CORE_OUT,
  input wire logic [NPINS-1:0] CORE_OE,
  input wire logic [NPINS-1:0] PAD_IN,
  output logic [NPINS-1:0] PAD_OUT,
  output logic [NPINS-1:0] PAD_OE,
  output logic [bst_pkg::BST_IR_W-1:0] INSTR
);
  import bst_pkg::*;
  localparam int BSR_W = 3 * NPINS;

  // elaboration check: at least one pin needs a cell
  if (NPINS < 1) begin : g_bad_npins
    $error("NPINS must be at least 1");
  end

  bst_ctrl_if cif ();
  logic tdi_s1_r, tdi_s2_r;
  logic [NPINS-1:0] pad_in_s1_r, pad_in_s2_r;

  // controller with tck/tms synchronisers
  bst_tap_fsm u_fsm (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .tck_pin(TCK),
    .tms_pin(TMS),
    .cif(cif)
  );

  // tdi and pad input synchronisers; only the second stage is read
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
      pad_in_s1_r <= '0;
      pad_in_s2_r <= '0;
    end else begin
      tdi_s1_r <= TDI;
      tdi_s2_r <= tdi_s1_r;
      pad_in_s1_r <= PAD_IN;
      pad_in_s2_r <= pad_in_s1_r;
    end
  end

  function automatic logic is_bsr_op(input logic [BST_IR_W-1:0] op);
    return (op == BST_OP_EXTEST) || (op == BST_OP_SAMPLE);
  endfunction

  logic [31:0] id_val;
  // id fields placed at their bit positions
  assign id_val[BST_ID_LSB_POS +: 8] = ID_LSB;
  assign id_val[BST_ID_NUM_POS +: 4] = ID_NUM;
  assign id_val[BST_ID_PART_POS +: 16] = ID_PART;
  assign id_val[BST_ID_VER_POS +: 4] = ID_VER;

  logic [BST_IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic byp_r, byp_nxt;
  logic [31:0] id_r, id_nxt;
  logic [BSR_W-1:0] bsr_sh_r, bsr_sh_nxt, bsr_up_r, bsr_up_nxt;
  logic [BSR_W-1:0] bsr_cap;
  logic tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;
  logic [NPINS-1:0] pad_out_r, pad_out_nxt, pad_oe_r, pad_oe_nxt;
  logic in_ir, in_dr, sel_bsr, sel_id;

  // per pin three cells: input, output data, output enable
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_cell
      assign bsr_cap[3*gi] = pad_in_s2_r[gi];
      assign bsr_cap[3*gi+1] = CORE_OUT[gi];
      assign bsr_cap[3*gi+2] = CORE_OE[gi];
    end
  endgenerate

  assign in_ir = (cif.state == BST_CAP_IR) || (cif.state == BST_SH_IR) || (cif.state == BST_UPD_IR);
  assign in_dr = (cif.state == BST_CAP_DR) || (cif.state == BST_SH_DR) || (cif.state == BST_UPD_DR);
  assign sel_bsr = is_bsr_op(ir_r);
  assign sel_id = (ir_r == BST_OP_IDCODE);

  // register actions on rising tck, tdo on falling tck
  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    id_nxt = id_r;
    bsr_sh_nxt = bsr_sh_r;
    bsr_up_nxt = bsr_up_r;
    tdo_nxt = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    if (cif.state == BST_TLR) begin
      ir_nxt = BST_IR_RESET;
    end else if (cif.rise) begin
      if (in_ir) begin
        if (cif.state == BST_CAP_IR) begin
          ir_sh_nxt = BST_IR_CAPTURE;
        end else if (cif.state == BST_SH_IR) begin
          ir_sh_nxt = {tdi_s2_r, ir_sh_r[BST_IR_W-1:1]};
        end else begin
          ir_nxt = ir_sh_r;
        end
      end else if (in_dr) begin
        if (sel_bsr) begin
          if (cif.state == BST_CAP_DR) begin
            bsr_sh_nxt = bsr_cap;
          end else if (cif.state == BST_SH_DR) begin
            bsr_sh_nxt = {tdi_s2_r, bsr_sh_r[BSR_W-1:1]};
          end else begin
            bsr_up_nxt = bsr_sh_r;
          end
        end else if (sel_id) begin
          if (cif.state == BST_CAP_DR) begin
            id_nxt = id_val;
          end else if (cif.state == BST_SH_DR) begin
            id_nxt = {tdi_s2_r, id_r[31:1]};
          end
        end else begin
          if (cif.state == BST_CAP_DR) begin
            byp_nxt = 1'b0;
          end else if (cif.state == BST_SH_DR) begin
            byp_nxt = tdi_s2_r;
          end
        end
      end
    end
    if (cif.fall) begin
      tdo_oe_nxt = (cif.state == BST_SH_IR) || (cif.state == BST_SH_DR);
      if (cif.state == BST_SH_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (sel_bsr) begin
        tdo_nxt = bsr_sh_r[0];
      end else if (sel_id) begin
        tdo_nxt = id_r[0];
      end else begin
        tdo_nxt = byp_r;
      end
    end
  end

  // pin drive: boundary cells under extest, core otherwise
  always_comb begin
    pad_out_nxt = CORE_OUT;
    pad_oe_nxt = CORE_OE;
    if (ir_r == BST_OP_EXTEST) begin
      for (int i = 0; i < NPINS; i++) begin
        pad_out_nxt[i] = bsr_up_r[3*i+1];
        pad_oe_nxt[i] = bsr_up_r[3*i+2];
      end
    end
  end

  // registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ir_sh_r <= '0;
      ir_r <= BST_IR_RESET;
      byp_r <= 1'b0;
      id_r <= '0;
      bsr_sh_r <= '0;
      bsr_up_r <= '0;
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
      pad_out_r <= '0;
      pad_oe_r <= '0;
    end else begin
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      id_r <= id_nxt;
      bsr_sh_r <= bsr_sh_nxt;
      bsr_up_r <= bsr_up_nxt;
      tdo_r <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
    end
  end

  assign TDO = tdo_r;
  assign TDO_OE = tdo_oe_r;
  assign PAD_OUT = pad_out_r;
  assign PAD_OE = pad_oe_r;
  assign INSTR = ir_r;
endmodule
`default_nettype wire

// ===== sim/bst_tap_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port checks of the test port
module bst_tap_chk import bst_pkg::*; #(
  parameter int NPINS = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic [NPINS-1:0] CORE_OUT,
  input wire logic [NPINS-1:0] CORE_OE,
  input wire logic [NPINS-1:0] PAD_IN,
  input wire logic [NPINS-1:0] PAD_OUT,
  input wire logic [NPINS-1:0] PAD_OE,
  input wire logic [BST_IR_W-1:0] INSTR
);
  logic tck_r;
  logic rise;
  logic [2:0] ones_r, ones_nxt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // counts tck rises seen with tms high
  assign rise = TCK && !tck_r;
  always_comb begin
    ones_nxt = ones_r;
    if (rise) ones_nxt = !TMS ? 3'h0 : (ones_r == 3'h5) ? 3'h5 : ones_r + 3'h1;
  end
  // registers the counter and the last tck level
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tck_r <= 1'b0;
      ones_r <= 3'h0;
    end else begin
      tck_r <= TCK;
      ones_r <= ones_nxt;
    end
  end
  property p_tdo_f; $changed(TDO) |-> !TCK; endproperty
  a_tdo_f: assert property (p_tdo_f) else $error("tdo moved while tck high");
  property p_oe_f; $changed(TDO_OE) |-> !TCK; endproperty
  a_oe_f: assert property (p_oe_f) else $error("tdo_oe moved while tck high");
  property p_oe_hold; $rose(TDO_OE) |=> TDO_OE [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("tdo_oe too short");
  property p_tdo_hold; $changed(TDO) |=> $stable(TDO) [*8]; endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo too short");
  property p_ir_rise; $changed(INSTR) |-> TCK; endproperty
  a_ir_rise: assert property (p_ir_rise) else $error("instr moved while tck low");
  property p_tlr; rise && TMS && ones_r == 3'h4 |-> ##[1:10] INSTR == BST_OP_IDCODE && !TDO_OE; endproperty
  a_tlr: assert property (p_tlr) else $error("no reset after five tms");
  property p_core;
    $past(RST_N) && INSTR != BST_OP_EXTEST && $past(INSTR) != BST_OP_EXTEST
      |-> PAD_OUT == $past(CORE_OUT) && PAD_OE == $past(CORE_OE);
  endproperty
  a_core: assert property (p_core) else $error("pads not following core");
  property p_ext;
    INSTR == BST_OP_EXTEST && $past(INSTR) == BST_OP_EXTEST && ($changed(PAD_OUT) || $changed(PAD_OE)) |-> TCK;
  endproperty
  a_ext: assert property (p_ext) else $error("pads moved off update");
  c_shift: cover property ($rose(TDO_OE));
  c_ext: cover property (INSTR == BST_OP_EXTEST);
  c_tlr: cover property (rise && TMS && ones_r == 3'h4);
endmodule
`default_nettype wire

// ===== sim/bst_tester.sv
`timescale 1ns/1ps
`default_nettype none
// test controller: drives tck, tms, tdi and samples tdo
module bst_tester (
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input wire logic TDO
);
  // tck rests low between frames
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // one 48 ns tck cycle, tms set up half a period before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    TMS = tms;
    TDI = tdi;
    #23 tdo = TDO;
    #1 TCK = 1'b1;
    #24 TCK = 1'b0;
  endtask
  // five rises with tms high
  task automatic reset5();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
  endtask
  // from idle: scan n bits lsb first through ir or dr, back to idle
  task automatic xfer(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    if (ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule
`default_nettype wire

// ===== sim/bst_tap_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the test port
module bst_tap_top_tb;
  import bst_pkg::*;
  localparam logic [31:0] ID = 32'h6c5e_2a3b;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] core = 6'h0;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [1:0] p_out, p_oe;
  logic [3:0] instr;
  int num_errors = 0;
  int checks_done = 0;
  // 250 MHz clock
  always #2 mclk = ~mclk;
  bst_tester tst_u (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo));
  // id field values are arbitrary
  bst_tap_top #(.NPINS(2), .ID_LSB(8'h3b), .ID_NUM(4'ha), .ID_PART(16'hc5e2), .ID_VER(4'h6)) dut_u (
    .MCLK(mclk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
    .CORE_OUT(core[1:0]), .CORE_OE(core[3:2]), .PAD_IN(core[5:4]), .PAD_OUT(p_out), .PAD_OE(p_oe),
    .INSTR(instr));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // load an instruction, then scan a data register
  task automatic t_op(input logic [3:0] op, input int n, input logic [31:0] din, input logic [31:0] exp);
    logic [31:0] d;
    tst_u.xfer(1'b1, 4, {28'h0, op}, d);
    chk("ir capture", d, 32'(BST_IR_CAPTURE));
    chk("instr", instr, op);
    tst_u.xfer(1'b0, n, din, d);
    chk("dr out", d, exp);
  endtask
  // sample pins and preload, then extest drives the preloaded cells
  task automatic t_ext();
    logic [31:0] d;
    @(posedge mclk);
    #1 core = 6'h36;
    repeat (2) @(posedge mclk);
    #1;
    chk("pad_out", p_out, 2'h2);
    t_op(BST_OP_SAMPLE, 6, 32'h2e, 32'h1d);
    tst_u.xfer(1'b1, 4, {28'h0, BST_OP_EXTEST}, d);
    @(posedge mclk);
    #1 core = 6'h02;
    repeat (2) @(posedge mclk);
    #1;
    chk("pad_out", p_out, 2'h1);
    chk("pad_oe", p_oe, 2'h3);
  endtask
  // five tms highs in mid shift return to reset
  task automatic t_tlr();
    logic d;
    tst_u.step(1'b1, 1'b0, d);
    tst_u.step(1'b0, 1'b0, d);
    tst_u.step(1'b0, 1'b0, d);
    #20;
    chk("tdo_oe", tdo_oe, 1'b1);
    tst_u.reset5();
    #20;
    chk("instr", instr, BST_OP_IDCODE);
    chk("tdo_oe", tdo_oe, 1'b0);
    chk("pad_out", p_out, 2'h2);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic d;
    logic [31:0] w;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("instr", instr, BST_OP_IDCODE);
    chk("tdo_oe", tdo_oe, 1'b0);
    tst_u.step(1'b0, 1'b0, d);
    tst_u.xfer(1'b0, 32, 32'h0, w);
    chk("idcode", w, ID);
    t_op(BST_OP_BYPASS, 8, 32'hb5, 32'h6a);
    t_op(4'h5, 8, 32'hb5, 32'h6a);
    t_op(BST_OP_IDCODE, 32, 32'h0, ID);
    t_ext();
    t_tlr();
    give_verdict();
  end
  // watchdog
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule
bind bst_tap_top bst_tap_chk #(.NPINS(NPINS)) chk_u (.MCLK(MCLK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS),
  .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .CORE_OUT(CORE_OUT), .CORE_OE(CORE_OE), .PAD_IN(PAD_IN),
  .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .INSTR(INSTR));
`default_nettype wire
